// ### hw/sdfc_consts.svh
// Summary of operation
// - A frame opens only when the host pulls frame sync low, and that falling edge arms the shift register.
// - While frame sync is low, each of the first sixteen falling shift-clock edges samples the data input into a 16-bit shift register.
// - The sixteenth falling shift-clock edge takes the last bit and loads code and power mode together.
// - Sync rising before the sixteenth edge clears the shift register and leaves code and mode unchanged.
// - Frame bits 15 and 14 are the high and low power-mode select bits.
// - The code starts at bit 13, most significant first, is 12, 10 or 8 bits wide, and lower bits are ignored.
// - Mode 00 is normal, 01 ties the output to ground through 1 kOhm, 10 through 100 kOhm, and 11 is high impedance.
// - The code is straight unsigned binary, full scale 255, 1023 or 4095, output equal to supply times code over two to the width.
// - Reset loads a zero code, which stays until a complete valid frame arrives.
// - Any power-down mode disables the linear circuitry and switches the output to the selected termination.
// - A power-down frame still loads its code field, so the stored code changes with every complete frame.
// - After a frame returns the block from power-down to normal, the output is flagged valid after a 50 us wake-up delay.
`ifndef SDFC_CONSTS_SVH
`define SDFC_CONSTS_SVH
`define SDFC_FRAME_BITS    16
`define SDFC_CNT_W         5
`define SDFC_MODE_HI_POS   15
`define SDFC_MODE_LO_POS   14
`define SDFC_CODE_TOP_POS  13
`define SDFC_CLK_PERIOD_PS 8000
`define SDFC_WAKE_TIME_NS  50000
`define SDFC_SYNC_HIGH_NS  20
`define SDFC_RES_DEFAULT   12
`endif

// ### hw/sdfc_pkg.sv
package sdfc_pkg;
  // Power mode field decode.
  typedef enum logic [1:0] {
    SDFC_MODE_NORMAL = 2'h0,
    SDFC_MODE_PD_1K  = 2'h1,
    SDFC_MODE_PD_100K = 2'h2,
    SDFC_MODE_PD_HIZ = 2'h3
  } sdfc_mode_e;
  // Receiver state.
  typedef enum logic [1:0] {
    SDFC_IDLE,
    SDFC_SHIFT,
    SDFC_DONE
  } sdfc_rx_e;
endpackage

// ### hw/sdfc_sync3.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; a change counts once stages two and three agree.
module sdfc_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset.
  input  wire logic clock,
  input  wire logic rst_n,
  // Asynchronous input and filtered level.
  input  wire logic async_in,
  output logic      level
);
  logic [2:0] stage_q;
  logic [2:0] stage_d;
  logic       level_q;
  logic       level_d;

  // Next values: shift in, and follow only when the last two stages agree.
  always_comb begin
    stage_d = {stage_q[1:0], async_in};
    level_d = (stage_q[1] == stage_q[2]) ? stage_q[2] : level_q;
  end

  // Registers.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stage_q <= {3{RESET_VAL}};
      level_q <= RESET_VAL;
    end else begin
      stage_q <= stage_d;
      level_q <= level_d;
    end
  end

  assign level = level_q;
endmodule
`default_nettype wire

// ### hw/sdfc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdfc_consts.svh"
// Serial converter frame control: receives 16-bit frames and holds code and mode.
module sdfc_top
  import sdfc_pkg::*;
#(
  parameter int RES_BITS       = `SDFC_RES_DEFAULT,
  parameter int WAKE_TIME_NS   = `SDFC_WAKE_TIME_NS
) (
  // Clock and reset.
  input  wire logic                clock,
  input  wire logic                rst_n,
  // Serial link pins.
  input  wire logic                sync_n,
  input  wire logic                sclk,
  input  wire logic                sdin,
  // Converter code and output control.
  output logic [RES_BITS-1:0]      dac_code,
  output logic                     pwr_mode_sel_hi,
  output logic                     pwr_mode_sel_lo,
  output logic                     amp_enable,
  output logic                     term_1k_en,
  output logic                     term_100k_en,
  output logic                     output_valid,
  // Frame status.
  output logic                     frame_done,
  output logic                     frame_abort
);
  // Wake delay in cycles, rounded up; a minimum time never rounds down.
  localparam int WAKE_CYC = (WAKE_TIME_NS * 1000 + `SDFC_CLK_PERIOD_PS - 1)
                            / `SDFC_CLK_PERIOD_PS;
  localparam int WAKE_W   = $clog2(WAKE_CYC + 1);

  // Only the three documented resolutions fit the 14 bits after the mode field.
  initial begin
    if (RES_BITS != 8 && RES_BITS != 10 && RES_BITS != 12) begin
      $error("sdfc_top: RES_BITS must be 8, 10 or 12");
    end
    if (WAKE_CYC < 1) begin
      $error("sdfc_top: wake delay too short");
    end
  end

  logic sync_n_s;
  logic sclk_s;
  logic sdin_s;

  // Pins come from the host's domain and pass the three-stage filter.
  sdfc_sync3 #(.RESET_VAL(1'b1)) u_sync_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in (sync_n),
    .level    (sync_n_s)
  );
  sdfc_sync3 #(.RESET_VAL(1'b0)) u_sync_sclk (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in (sclk),
    .level    (sclk_s)
  );
  sdfc_sync3 #(.RESET_VAL(1'b0)) u_sync_sdin (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in (sdin),
    .level    (sdin_s)
  );

  // Edge detection on the filtered levels. Data is delayed like the clock,
  // so the sampled bit is the one present just before the falling edge.
  logic sync_prev_q;
  logic sclk_prev_q;
  logic sync_fall;
  logic sync_rise;
  logic sclk_fall;
  assign sync_fall = sync_prev_q & ~sync_n_s;
  assign sync_rise = ~sync_prev_q & sync_n_s;
  assign sclk_fall = sclk_prev_q & ~sclk_s;

  // Receiver state.
  sdfc_rx_e                       rx_q;
  sdfc_rx_e                       rx_d;
  logic [`SDFC_FRAME_BITS-1:0]    shreg_q;
  logic [`SDFC_FRAME_BITS-1:0]    shreg_d;
  logic [`SDFC_CNT_W-1:0]         cnt_q;
  logic [`SDFC_CNT_W-1:0]         cnt_d;
  logic [`SDFC_FRAME_BITS-1:0]    full_word;
  logic                           exec;
  logic                           abort;

  assign full_word = {shreg_q[`SDFC_FRAME_BITS-2:0], sdin_s};

  // Receiver next state: arm on sync fall, shift on sclk fall, execute on 16th.
  always_comb begin
    rx_d    = rx_q;
    shreg_d = shreg_q;
    cnt_d   = cnt_q;
    exec    = 1'b0;
    abort   = 1'b0;
    case (rx_q)
      SDFC_IDLE: begin
        if (sync_fall) begin
          rx_d    = SDFC_SHIFT;
          shreg_d = '0;
          cnt_d   = '0;
        end
      end
      SDFC_SHIFT: begin
        if (sync_n_s) begin
          // Early rise: frame invalid, nothing is loaded.
          rx_d    = SDFC_IDLE;
          shreg_d = '0;
          cnt_d   = '0;
          abort   = 1'b1;
        end else if (sclk_fall) begin
          shreg_d = full_word;
          if (cnt_q == 5'(`SDFC_FRAME_BITS - 1)) begin
            rx_d = SDFC_DONE;
            exec = 1'b1;
            cnt_d = '0;
          end else begin
            cnt_d = cnt_q + 5'h01;
          end
        end
      end
      SDFC_DONE: begin
        // Further clocks are ignored until sync goes high.
        if (sync_n_s) begin
          rx_d = SDFC_IDLE;
        end
      end
      default: begin
        rx_d = SDFC_IDLE;
      end
    endcase
  end

  // Code and mode registers, and the wake-up timer.
  logic [RES_BITS-1:0]  code_q;
  logic [RES_BITS-1:0]  code_d;
  logic [1:0]           mode_q;
  logic [1:0]           mode_d;
  logic [WAKE_W-1:0]    wake_q;
  logic [WAKE_W-1:0]    wake_d;

  // Execution loads code and mode together; a power-down frame still loads
  // its code field, so dac_code changes on that frame and not only on a later normal frame.
  always_comb begin
    code_d = code_q;
    mode_d = mode_q;
    wake_d = wake_q;
    if (exec) begin
      // Mode field from the top two bits, code right after, extra bits dropped.
      mode_d = {full_word[`SDFC_MODE_HI_POS], full_word[`SDFC_MODE_LO_POS]};
      code_d = full_word[`SDFC_CODE_TOP_POS -: RES_BITS];
      if (mode_q != SDFC_MODE_NORMAL && mode_d == SDFC_MODE_NORMAL) begin
        wake_d = WAKE_W'(WAKE_CYC);
      end
    end else if (wake_q != '0) begin
      wake_d = wake_q - WAKE_W'(1);
    end
  end

  // Registers; reset zeroes the code so the output starts at 0 V.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rx_q        <= SDFC_IDLE;
      shreg_q     <= '0;
      cnt_q       <= '0;
      sync_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
      code_q      <= '0;
      mode_q      <= 2'h0;
      wake_q      <= '0;
      frame_done  <= 1'b0;
      frame_abort <= 1'b0;
    end else begin
      rx_q        <= rx_d;
      shreg_q     <= shreg_d;
      cnt_q       <= cnt_d;
      sync_prev_q <= sync_n_s;
      sclk_prev_q <= sclk_s;
      code_q      <= code_d;
      mode_q      <= mode_d;
      wake_q      <= wake_d;
      frame_done  <= exec;
      frame_abort <= abort;
    end
  end

  // Straight binary code goes to the string unchanged.
  assign dac_code        = code_q;
  assign pwr_mode_sel_hi = mode_q[1];
  assign pwr_mode_sel_lo = mode_q[0];
  // Output stage decode: amplifier only in normal mode, one termination in the 1k and 100k modes, none in high impedance.
  assign amp_enable      = (mode_q == SDFC_MODE_NORMAL);
  assign term_1k_en      = (mode_q == SDFC_MODE_PD_1K);
  assign term_100k_en    = (mode_q == SDFC_MODE_PD_100K);
  assign output_valid    = amp_enable && (wake_q == '0);

  // Checks.
  code_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
    !frame_done |-> $stable(dac_code))
    else $error("code changed without a frame");
  abort_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
    frame_abort |-> $stable(dac_code) && $stable(mode_q) && shreg_q == '0)
    else $error("aborted frame changed state");
  arm_on_fall_a: assert property (@(posedge clock) disable iff (!rst_n)
    rx_q == SDFC_IDLE && sync_fall |=> rx_q == SDFC_SHIFT && cnt_q == '0)
    else $error("frame not armed on sync fall");
  shift_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
    rx_q == SDFC_SHIFT && !sync_n_s && sclk_fall |=> shreg_q[0] == $past(sdin_s))
    else $error("bit not shifted in");
  exec_load_a: assert property (@(posedge clock) disable iff (!rst_n)
    exec |=> frame_done && mode_q == $past(full_word[15:14])
             && dac_code == $past(full_word[13 -: RES_BITS]))
    else $error("frame did not load code and mode");
  done_ignore_a: assert property (@(posedge clock) disable iff (!rst_n)
    rx_q == SDFC_DONE && !sync_n_s |=> !frame_done && rx_q == SDFC_DONE)
    else $error("clock after frame end was taken");
  pd_output_a: assert property (@(posedge clock) disable iff (!rst_n)
    mode_q != SDFC_MODE_NORMAL |-> !amp_enable && !output_valid
             && (term_1k_en + term_100k_en <= 1))
    else $error("power-down output stage wrong");
  wake_start_a: assert property (@(posedge clock) disable iff (!rst_n)
    exec && mode_q != SDFC_MODE_NORMAL && mode_d == SDFC_MODE_NORMAL
      |=> !output_valid [*8])
    else $error("output valid before wake-up delay");
  hiz_mode_a: assert property (@(posedge clock) disable iff (!rst_n)
    mode_q == SDFC_MODE_PD_HIZ |-> !term_1k_en && !term_100k_en)
    else $error("high impedance mode drives a termination");

  frame_ok_c: cover property (@(posedge clock) disable iff (!rst_n) frame_done);
  frame_abort_c: cover property (@(posedge clock) disable iff (!rst_n) frame_abort);
  wake_c: cover property (@(posedge clock) disable iff (!rst_n)
    $rose(output_valid) && wake_q == '0);
endmodule
`default_nettype wire

// ### tb/sdfc_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host serial port model; the shift clock is parked high outside frames.
module sdfc_host (
  // Serial link pins.
  output logic sync_n,
  output logic sclk,
  output logic sdin
);
  // Idle levels before the first frame.
  initial begin
    sync_n = 1'b1;
    sclk   = 1'b1;
    sdin   = 1'b0;
  end

  // Sends nbits MSB first, then extra edges with sync still low, then releases.
  task automatic send(input logic [15:0] f, input int nbits, input int extra);
    sync_n = 1'b0;
    #62.5;
    for (int i = 0; i < nbits + extra; i++) begin
      sdin = (i < 16) ? f[15-i] : ~sdin;
      #62.5 sclk = 1'b0;
      #62.5 sclk = 1'b1;
    end
    #62.5 sync_n = 1'b1;
    sdin = ~sdin; // A released line must not keep its last value.
    #100;
  endtask
endmodule
`default_nettype wire

// ### tb/sdfc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the serial converter frame control.
module sdfc_top_tb;
  import sdfc_pkg::*;
  logic        clock;
  logic        rst_n;
  logic        sync_n;
  logic        sclk;
  logic        sdin;
  logic [11:0] dac_code;
  logic        sel_hi;
  logic        sel_lo;
  logic        amp_enable;
  logic        term_1k_en;
  logic        term_100k_en;
  logic        output_valid;
  logic        frame_done;
  logic        frame_abort;
  int          bad_count;
  int          total_checks;
  int          done_cnt;
  int          abort_cnt;
  int          d;
  int          n;
  logic [11:0] codes [4] = '{12'h000, 12'hFFF, 12'h800, 12'h123};

  // Short wake time keeps the run brief; 25 cycles at 8 ns.
  sdfc_top #(.RES_BITS(12), .WAKE_TIME_NS(200)) sdfc_top_inst (
    .clock(clock), .rst_n(rst_n), .sync_n(sync_n), .sclk(sclk), .sdin(sdin),
    .dac_code(dac_code), .pwr_mode_sel_hi(sel_hi), .pwr_mode_sel_lo(sel_lo),
    .amp_enable(amp_enable), .term_1k_en(term_1k_en), .term_100k_en(term_100k_en),
    .output_valid(output_valid), .frame_done(frame_done), .frame_abort(frame_abort)
  );
  sdfc_host sdfc_host_inst (.sync_n(sync_n), .sclk(sclk), .sdin(sdin));

  // System clock at 125 MHz.
  initial clock = 1'b0;
  always #4 clock = ~clock;

  // Counts the one-cycle status pulses so none can slip by unseen.
  always @(posedge clock) begin
    if (frame_done === 1'b1) done_cnt++;
    if (frame_abort === 1'b1) abort_cnt++;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic complete_run();
    if (bad_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Bounded wait for the frame counter to reach a value; the bound covers a
  // whole frame of 16 slow link clocks when the wait runs beside the send.
  task automatic wait_done(input int want);
    for (int i = 0; i < 400; i++) begin
      if (done_cnt == want) return;
      @(negedge clock);
    end
    bad_count++;
    complete_run();
  endtask

  task automatic check_state(input logic [1:0] m, input logic [11:0] c);
    chk("code", 16'(c), 16'(dac_code));
    chk("mode", 16'(m), 16'({sel_hi, sel_lo}));
    chk("drive", 16'({m == 2'h0, m == 2'h1, m == 2'h2}),
        16'({amp_enable, term_1k_en, term_100k_en}));
  endtask

  // Main sequence; reset changes on the falling clock edge, the host pins on their own 62.5 ns steps.
  initial begin
    rst_n = 1'b0;
    bad_count = 0;
    total_checks = 0;
    done_cnt = 0;
    abort_cnt = 0;
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    check_state(2'h0, 12'h000);
    chk("valid", 16'h1, 16'(output_valid));
    // Every power-down mode, low don't-care bits set.
    for (int m = 1; m < 4; m++) begin
      d = done_cnt;
      sdfc_host_inst.send({2'(m), codes[m], 2'b11}, 16, 0);
      wait_done(d + 1);
      check_state(2'(m), codes[m]);
    end
    // Early release while powered down leaves code and mode alone.
    d = abort_cnt;
    sdfc_host_inst.send({2'h0, 12'hABC, 2'h0}, 15, 0);
    repeat (10) @(negedge clock);
    chk("abort", 16'(d + 1), 16'(abort_cnt));
    chk("done", 16'h3, 16'(done_cnt));
    check_state(2'h3, codes[3]);
    // Return to normal and time the wake-up delay.
    d = done_cnt;
    fork
      sdfc_host_inst.send({2'h0, 12'h7E1, 2'h0}, 16, 0);
      begin
        wait_done(d + 1);
        chk("wake low", 16'h0, 16'(output_valid));
        n = 0;
        while (output_valid !== 1'b1 && n < 60) begin
          @(negedge clock);
          n++;
        end
        chk("wake time", 16'h1, 16'(n >= 20 && n <= 26));
      end
    join
    check_state(2'h0, 12'h7E1);
    // Extra edges after the sixteenth with sync held low are ignored.
    d = done_cnt;
    sdfc_host_inst.send({2'h0, 12'h5A5, 2'h0}, 16, 17);
    repeat (10) @(negedge clock);
    chk("one exec", 16'(d + 1), 16'(done_cnt));
    check_state(2'h0, 12'h5A5);
    // Back-to-back frame after the host's 100 ns release wait and ten clock cycles of sync high.
    sdfc_host_inst.send({2'h1, 12'h001, 2'h0}, 16, 0);
    wait_done(d + 2);
    check_state(2'h1, 12'h001);
    complete_run();
  end
endmodule
`default_nettype wire
